//--- src/dgp_port_mux.sv
// Purpose: Routes six port pins among DSP bits, trigger latches, pulses and irq.
// Assumes: Pins synchronous to clk_sys_in; pull-ups realised in the pad ring.
// Notes:   Configuration written through a register-number write port.
`default_nettype none

module dgp_port_mux (
	input  wire logic                 clk_sys_in,   // System clock
	input  wire logic                 srst_in,      // DSP reset, active high
	input  wire dgp_pkg::dgp_cfg_wr_t cfg_wr_in,    // Config register write
	input  wire logic [7:0]           cfg_raddr_in, // Config read address
	output logic [7:0]                cfg_rdata_out,// Config read data
	input  wire logic [5:0]           pin_in,       // Pad input levels
	output dgp_pkg::dgp_pin_drv_t     pin_drv_out,  // Pad drive, enable, pull
	input  wire logic [5:0]           dsp_bit_in,   // DSP output bits 0..5
	input  wire logic                 dsp_stop_in,  // DSP stop pulse
	input  wire logic                 irq_set_in,   // DSP interrupt set pulse
	input  wire logic                 ssn_rise_in,  // SPI select rising edge
	input  wire logic                 i2c_stop_in,  // I2C stop condition
	input  wire logic                 spi_mode_in,  // Serial link in SPI mode
	input  wire logic                 i2c_mode_in,  // Serial link in I2C mode
	input  wire logic                 spi_miso_in,  // MISO data from serial unit
	input  wire logic                 spi_miso_oe_in, // MISO drive enable
	input  wire logic                 pulse_a_in,   // Pulse code output a
	input  wire logic                 pulse_b_in,   // Pulse code output b
	input  wire logic                 mux_sel_in,   // Cap/guard mux select
	input  wire logic                 mux_sel_en_in,// Mux select owns pin 4 unless irq is routed there
	output logic                      ssn_out,      // Select from pin 0
	output logic                      dsp_start_out,// DSP start pulse
	output logic [7:0]                cond_in_out,  // DSP condition inputs 48..55
	output logic [3:0]                dsp_gpin_out, // DSP readable pin levels
	output logic                      irq_level_out // Irq status for DSP
);

	// ==========================================================
	// Configuration registers
	logic [7:0] filt_route_q; // port_filter_pulse_route_cfg
	logic [7:0] trig_mask_q;  // trigger_pin_mask_cfg
	logic [7:0] irq_route_q;  // interrupt_pin_route_cfg
	logic [7:0] dir_pull_q;   // port_direction_pullup_cfg

	// Register-number write port
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			filt_route_q <= dgp_pkg::DGP_CFG_RESET;
			trig_mask_q  <= dgp_pkg::DGP_CFG_RESET;
			irq_route_q  <= dgp_pkg::DGP_CFG_RESET;
			dir_pull_q   <= dgp_pkg::DGP_DIR_RESET;
		end else if (cfg_wr_in.we) begin
			unique case (cfg_wr_in.addr)
				dgp_pkg::DGP_REG_FILT_ROUTE: filt_route_q <= cfg_wr_in.wdata;
				dgp_pkg::DGP_REG_TRIG_MASK:  trig_mask_q  <= cfg_wr_in.wdata;
				dgp_pkg::DGP_REG_IRQ_ROUTE:  irq_route_q  <= cfg_wr_in.wdata;
				dgp_pkg::DGP_REG_DIR_PULL:   dir_pull_q   <= cfg_wr_in.wdata;
				default: begin
					// Other register numbers belong to other blocks
				end
			endcase
		end
	end

	// Read back; unmapped numbers read zero
	always_comb begin
		unique case (cfg_raddr_in)
			dgp_pkg::DGP_REG_FILT_ROUTE: cfg_rdata_out = filt_route_q;
			dgp_pkg::DGP_REG_TRIG_MASK:  cfg_rdata_out = trig_mask_q;
			dgp_pkg::DGP_REG_IRQ_ROUTE:  cfg_rdata_out = irq_route_q;
			dgp_pkg::DGP_REG_DIR_PULL:   cfg_rdata_out = dir_pull_q;
			default:                     cfg_rdata_out = 8'h00;
		endcase
	end

	// ==========================================================
	// Field decode
	logic [3:0] dir_in;   // 1 = input
	logic [3:0] pull_en;  // Pull-up enables
	logic       sel_a;    // Pulse a to pin 2
	logic       sel_b;    // Pulse b to pin 3
	logic [1:0] deb_en;   // Debounce enables, pins 0 and 1

	assign dir_in  = dir_pull_q[dgp_pkg::DGP_DIR_LSB +: 4];
	assign pull_en = dir_pull_q[dgp_pkg::DGP_PULL_LSB +: 4];
	assign deb_en  = {filt_route_q[dgp_pkg::DGP_BIT_DEB_PIN1],
		filt_route_q[dgp_pkg::DGP_BIT_DEB_PIN0]};
	// Outside I2C mode the pulses stay on pins 0 and 1
	assign sel_a = filt_route_q[dgp_pkg::DGP_BIT_PULSE_A_SEL] & i2c_mode_in;
	assign sel_b = filt_route_q[dgp_pkg::DGP_BIT_PULSE_B_SEL] & i2c_mode_in;

	// ==========================================================
	// Debounce on pins 0..3; upper two always bypassed
	logic [3:0] filt_pin; // Filtered input levels

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_deb
			logic deb_on; // Filter active for this pin
			assign deb_on = (gi < 2) ? deb_en[gi % 2] & dir_in[gi] : 1'b0;
			dgp_debounce u_deb (
				.clk_sys_in (clk_sys_in),
				.srst_in    (srst_in),
				.en_in      (deb_on),
				.raw_in     (pin_in[gi]),
				.filt_out   (filt_pin[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Trigger latches
	logic [3:0] prev_q;    // Previous filtered level
	logic [3:0] latch_q;   // trig_latch_zero..three
	logic [3:0] dbit_q;    // Previous DSP bits 0..3
	logic [3:0] fall;      // Accepted falling edges
	logic [3:0] fw_clr;    // Firmware set-then-clear
	logic [3:0] pin_live;  // Pins usable as trigger inputs

	// SPI owns pins 0 and 1
	assign pin_live = dir_in & {2'b11, ~{2{spi_mode_in}}};
	assign fall   = prev_q & ~filt_pin & trig_mask_q[3:0] & pin_live;
	assign fw_clr = dbit_q & ~dsp_bit_in[3:0];

	// Edge history
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			prev_q <= 4'hF;
			dbit_q <= 4'h0;
		end else begin
			prev_q <= filt_pin;
			dbit_q <= dsp_bit_in[3:0];
		end
	end

	// Latch holds until reset, stop or firmware clear; new edge wins
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			latch_q <= 4'h0;
		end else begin
			latch_q <= (latch_q & ~(fw_clr | {4{dsp_stop_in}})) | fall;
		end
	end

	// Start pulse registered from the edge
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			dsp_start_out <= 1'b0;
		end else begin
			dsp_start_out <= |fall;
		end
	end

	// Condition inputs 48..55: latches low, upper four bits zero
	assign cond_in_out  = {4'h0, latch_q};
	assign dsp_gpin_out = filt_pin;

	// ==========================================================
	// Interrupt line; set wins over clear
	logic irq_q; // Asserted interrupt

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			irq_q <= 1'b0;
		end else if (irq_set_in) begin
			irq_q <= 1'b1;
		end else if (ssn_rise_in || i2c_stop_in) begin
			irq_q <= 1'b0;
		end
	end

	assign irq_level_out = irq_q;

	// ==========================================================
	// Pin drive
	logic [5:0] dout_d; // Next drive values
	logic [5:0] oe_d;   // Next enables
	logic [5:0] dout_q; // Registered drive
	logic [5:0] oe_q;   // Registered enables
	logic [3:0] pu_q;   // Registered pull-ups

	always_comb begin
		dout_d = dsp_bit_in;
		oe_d   = {2'b11, ~dir_in};
		// Pulse a: OR lets it through only while the DSP bit is clear
		if (sel_a) dout_d[2] = dsp_bit_in[2] | pulse_a_in;
		else       dout_d[0] = dsp_bit_in[0] | pulse_a_in;
		if (sel_b) dout_d[3] = dsp_bit_in[3] | pulse_b_in;
		else       dout_d[1] = dsp_bit_in[1] | pulse_b_in;
		if (spi_mode_in) begin
			oe_d[0]   = 1'b0;           // Select is an input
			dout_d[0] = 1'b0;
			oe_d[1]   = spi_miso_oe_in;
			dout_d[1] = spi_miso_in;
		end
		if (mux_sel_en_in) dout_d[4] = mux_sel_in;
		if (irq_route_q[dgp_pkg::DGP_BIT_IRQ_PIN4]) dout_d[4] = ~irq_q;
		if (irq_route_q[dgp_pkg::DGP_BIT_IRQ_PIN5]) dout_d[5] = ~irq_q;
	end

	// Registered pad drive avoids glitches on mode changes
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			dout_q <= 6'h00;
			oe_q   <= 6'h30;
			pu_q   <= 4'h0;
		end else begin
			dout_q <= dout_d;
			oe_q   <= oe_d;
			pu_q   <= pull_en;
		end
	end

	assign pin_drv_out = '{dout: dout_q, oe: oe_q, pu: pu_q};
	assign ssn_out     = pin_in[0];

	// ==========================================================
	// Checks
	a_trig_latch_set: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		fall[2] |=> latch_q[2])
		else $error("trigger latch did not set");
	a_latch_hold: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(latch_q[0] && !fw_clr[0] && !dsp_stop_in) |=> latch_q[0])
		else $error("trigger latch dropped");
	a_start_edge: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(trig_mask_q[3] && dir_in[3] && $fell(filt_pin[3])) |=> dsp_start_out)
		else $error("no start on falling edge");
	a_mask_block: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(!trig_mask_q[2] && !latch_q[2]) |=> !latch_q[2])
		else $error("masked pin set latch");
	a_irq_clear: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(ssn_rise_in && !irq_set_in) |=> !irq_level_out)
		else $error("interrupt not cleared");
	a_irq_pin5: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		irq_route_q[7] |=> pin_drv_out.dout[5] == ~$past(irq_q))
		else $error("pin 5 not carrying irq");
	a_fw_clear: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(fw_clr[1] && !fall[1]) |=> !latch_q[1])
		else $error("firmware clear ignored");
	a_dir_enable: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(!spi_mode_in && dir_in[2]) |=> !pin_drv_out.oe[2])
		else $error("input pin driven");
	a_spi_select_in: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		spi_mode_in |=> !pin_drv_out.oe[0])
		else $error("select pin driven in spi mode");

endmodule : dgp_port_mux

`default_nettype wire

//--- src/dgp_pkg.sv
// Purpose: Shared constants and carriers for the DSP general-purpose port mux.
// Assumes: 100 MHz system clock, synchronous active-high reset.
// Notes:   Register offsets are configuration register numbers.
`default_nettype none

package dgp_pkg;

	// ==========================================================
	// Configuration register offsets
	localparam logic [7:0] DGP_REG_FILT_ROUTE = 8'h1B; // port_filter_pulse_route_cfg
	localparam logic [7:0] DGP_REG_TRIG_MASK  = 8'h1D; // trigger_pin_mask_cfg
	localparam logic [7:0] DGP_REG_IRQ_ROUTE  = 8'h1E; // interrupt_pin_route_cfg
	localparam logic [7:0] DGP_REG_DIR_PULL   = 8'h21; // port_direction_pullup_cfg

	// ==========================================================
	// Field positions
	localparam int DGP_BIT_PULSE_A_SEL = 0; // pulse_a_route_sel in filter/route cfg
	localparam int DGP_BIT_PULSE_B_SEL = 1; // pulse_b_route_sel in filter/route cfg
	localparam int DGP_BIT_DEB_PIN0    = 6; // debounce_enable for pin 0
	localparam int DGP_BIT_DEB_PIN1    = 7; // debounce_enable for pin 1
	localparam int DGP_BIT_IRQ_PIN4    = 6; // irq_on_pin_four_en
	localparam int DGP_BIT_IRQ_PIN5    = 7; // irq_on_pin_five_en
	localparam int DGP_DIR_LSB         = 4; // port_direction field low bit
	localparam int DGP_PULL_LSB        = 0; // port_pullup_enable field low bit

	// ==========================================================
	// Reset values
	localparam logic [7:0] DGP_CFG_RESET = 8'h00; // Filter/route, trigger mask and irq route cleared
	localparam logic [7:0] DGP_DIR_RESET = 8'hF0; // Pins 0..3 inputs after reset

	// ==========================================================
	// Timing
	localparam int DGP_CLK_MHZ      = 100;   // System clock rate
	localparam int DGP_DEBOUNCE_MS  = 40;    // Monoflop window
	localparam int DGP_DEBOUNCE_CYC = DGP_DEBOUNCE_MS * 1000 * DGP_CLK_MHZ;
	localparam int DGP_CNT_W        = 23;    // Holds 4,000,000

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] wdata; // Write data
		logic [7:0] addr;  // Register number
		logic       we;    // Write strobe
	} dgp_cfg_wr_t;

	typedef struct packed {
		logic [5:0] dout; // Pin drive values
		logic [5:0] oe;   // Pin output enables
		logic [3:0] pu;   // Pull-up enables
	} dgp_pin_drv_t;

endpackage : dgp_pkg

`default_nettype wire

//--- src/dgp_debounce.sv
// Purpose: 40 ms monoflop debounce for one port input.
// Assumes: Input synchronous to clk_sys_in.
// Notes:   First edge passes at once; further edges ignored for the window.
`default_nettype none

module dgp_debounce #(
	parameter int WINDOW_CYC = dgp_pkg::DGP_DEBOUNCE_CYC // Window length in cycles
) (
	input  wire logic clk_sys_in, // System clock
	input  wire logic srst_in,    // Synchronous reset
	input  wire logic en_in,      // Filter enable
	input  wire logic raw_in,     // Raw pin level
	output logic      filt_out    // Filtered level
);

	// ==========================================================
	// State
	logic [dgp_pkg::DGP_CNT_W-1:0] cnt_q; // Remaining hold cycles
	logic                          lvl_q; // Held level

	// Accept an edge, then freeze the level until the window expires
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cnt_q <= '0;
			lvl_q <= 1'b1; // Idle high like a pulled-up switch
		end else if (!en_in) begin
			cnt_q <= '0;
			lvl_q <= raw_in; // Bypass keeps the held level current
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1; // Bounces ignored here
		end else if (raw_in != lvl_q) begin
			lvl_q <= raw_in;
			cnt_q <= dgp_pkg::DGP_CNT_W'(WINDOW_CYC - 1);
		end
	end

	assign filt_out = lvl_q; // Filtered level

	// Held level cannot change while the window runs
	a_hold_window: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(en_in && cnt_q != '0) |=> $stable(lvl_q))
		else $error("debounce level changed inside window");

endmodule : dgp_debounce

`default_nettype wire

//--- tb/dgp_pin_partner.sv
// Purpose: Pad-side model: switches to ground, pull-ups and loads on six pins.
// Assumes: A closed switch is stronger than a pull-up but weaker than a driver.
// Notes:   A pin that nothing drives or pulls toggles each cycle, never holds.
`default_nettype none

module dgp_pin_partner (
	input  wire logic                  clk_sys_in, // System clock
	input  wire dgp_pkg::dgp_pin_drv_t drv_in,     // Device drive, enable, pull
	input  wire logic [5:0]            sw_low_in,  // Switch closed to ground
	output logic [5:0]                 pin_out     // Resolved pad levels
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Floating pattern
	logic       float_q = 1'b0;  // Changes every cycle so a float is never a level
	logic [5:0] pull;            // Pull-ups exist on pins 0..3 only

	always_ff @(posedge clk_sys_in) begin
		float_q <= ~float_q;
	end

	// ==========================================================
	// Wire resolution
	always_comb begin
		pull = {2'b00, drv_in.pu};
		for (int i = 0; i < 6; i++) begin
			if (drv_in.oe[i]) begin
				pin_out[i] = drv_in.dout[i];
			end else if (sw_low_in[i]) begin
				pin_out[i] = 1'b0;
			end else if (pull[i]) begin
				pin_out[i] = 1'b1;
			end else begin
				pin_out[i] = float_q ^ i[0];
			end
		end
	end
endmodule // dgp_pin_partner

`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the general-purpose port mux.
// Assumes: The debounce window never expires here; only its hold is exercised.
// Notes:   Expectations come from the small behavioural model in this file.
`default_nettype none
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin fails++; \
	$display("Error t=%0t got %h exp %h", $time, x, y); end end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Stimulus, wiring and model state
	logic                  clk_sys_in = 1'b0; // System clock
	logic                  srst_in    = 1'b1; // Reset, high
	dgp_pkg::dgp_cfg_wr_t  cfg_wr     = '0;   // Config write port
	logic [7:0]            raddr      = 8'h00;
	logic [5:0]            dbit       = 6'h00; // DSP output bits
	logic [5:0]            sw_low     = 6'h00; // Switches closed
	logic stop = 1'b0, iset = 1'b0, ssn_r = 1'b0, i2c_stop = 1'b0, spi = 1'b0, i2c = 1'b0;
	logic miso = 1'b0, miso_oe = 1'b0, pa = 1'b0, pb = 1'b0, msel = 1'b0, msel_en = 1'b0;
	wire logic [7:0]       rdata, cond;
	wire logic [5:0]       pins;
	wire logic [3:0]       gpin;
	wire logic             ssn, start, irq;
	dgp_pkg::dgp_pin_drv_t drv, e;
	int                    fails = 0, n_tests = 0, nst;
	integer                seed = 32'h34027D9F; // Random seed
	logic [7:0]            r27, r29, r30, r33; // Model registers
	logic [3:0]            latch_m = 4'h0;     // Model trigger latches
	logic                  irq_m = 1'b0;       // Model interrupt level

	always #5 clk_sys_in = ~clk_sys_in;

	dgp_port_mux i_dgp_port_mux (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .cfg_wr_in(cfg_wr),
		.cfg_raddr_in(raddr), .cfg_rdata_out(rdata), .pin_in(pins), .pin_drv_out(drv),
		.dsp_bit_in(dbit), .dsp_stop_in(stop), .irq_set_in(iset), .ssn_rise_in(ssn_r),
		.i2c_stop_in(i2c_stop), .spi_mode_in(spi), .i2c_mode_in(i2c), .spi_miso_in(miso),
		.spi_miso_oe_in(miso_oe), .pulse_a_in(pa), .pulse_b_in(pb), .mux_sel_in(msel),
		.mux_sel_en_in(msel_en), .ssn_out(ssn), .dsp_start_out(start), .cond_in_out(cond),
		.dsp_gpin_out(gpin), .irq_level_out(irq));
	dgp_pin_partner i_dgp_pin_partner (.clk_sys_in(clk_sys_in), .drv_in(drv),
		.sw_low_in(sw_low), .pin_out(pins));

	// ==========================================================
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	// One write, then an idle edge so the strobe is never re-raised in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_wr = '{wdata: d, addr: a, we: 1'b1};
		tick(1);
		cfg_wr.we = 1'b0;
		case (a)
			8'h1B: r27 = d;
			8'h1D: r29 = d;
			8'h1E: r30 = d;
			8'h21: r33 = d;
			default: ;
		endcase
		tick(1);
	endtask

	task automatic pls(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask

	task automatic chk_regs();
		// Address changes only just after an edge, like every other input
		raddr = 8'h1B;
		tick(1);
		`CHK(rdata, r27)
		raddr = 8'h1D;
		tick(1);
		`CHK(rdata, r29)
		raddr = 8'h1E;
		tick(1);
		`CHK(rdata, r30)
		raddr = 8'h21;
		tick(1);
		`CHK(rdata, r33)
		raddr = 8'h1C;
		tick(1);
		`CHK(rdata, 8'h00)
	endtask

	// Pad drive expected from configuration and current inputs
	task automatic chk_drv();
		tick(2);
		e.pu = r33[3:0];
		e.oe = {2'b11, ~r33[7:4]};
		e.dout = dbit;
		e.dout[0] = dbit[0] | (pa & ~(r27[0] & i2c));
		e.dout[2] = dbit[2] | (pa & r27[0] & i2c);
		e.dout[1] = dbit[1] | (pb & ~(r27[1] & i2c));
		e.dout[3] = dbit[3] | (pb & r27[1] & i2c);
		if (r30[6]) e.dout[4] = ~irq_m;
		else if (msel_en) e.dout[4] = msel;
		if (r30[7]) e.dout[5] = ~irq_m;
		if (spi) begin
			e.oe[1:0] = {miso_oe, 1'b0};
			e.dout[1] = miso;
		end
		`CHK(drv.oe, e.oe)
		`CHK(drv.pu, e.pu)
		`CHK(drv.dout & drv.oe, e.dout & e.oe)
		`CHK(irq, irq_m)
		`CHK(cond, {4'h0, latch_m})
	endtask

	// Close one switch and count start pulses; refused pins give none
	task automatic trig(input int n);
		logic fire;
		fire = r29[n] & r33[n + 4] & ~(spi & (n < 2));
		sw_low[n] = 1'b1;
		nst = 0;
		repeat (6) begin
			tick(1);
			nst += (start === 1'b1);
		end
		if (fire) latch_m[n] = 1'b1;
		`CHK(nst, int'(fire))
		`CHK(cond, {4'h0, latch_m})
		if (r33[n + 4]) `CHK(gpin[n], 1'b0)
		if (n == 0) `CHK(ssn, 1'b0)
		sw_low[n] = 1'b0;
		tick(3);
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Hang guard
	initial begin
		#500us;
		fails++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{r27, r29, r30, r33} = {8'h00, 8'h00, 8'h00, 8'hF0};
		tick(12);
		srst_in = 1'b0;
		chk_regs();
		chk_drv();
		// Random routing, pulses, modes and interrupt traffic
		repeat (12) begin
			wr(8'h1B, 8'($random(seed)));
			wr(8'h1E, 8'($random(seed)));
			wr(8'h21, 8'($random(seed)));
			wr(8'h1C, 8'($random(seed)));
			{dbit, pa, pb, i2c, spi, miso, miso_oe, msel, msel_en} = 14'($random(seed));
			if ($random(seed) & 1) begin
				pls(iset);
				irq_m = 1'b1;
			end else begin
				pls(ssn_r);
				irq_m = 1'b0;
			end
			chk_regs();
			chk_drv();
		end
		// Trigger latches with debounce off and pull-ups on
		{dbit, pa, pb, i2c, spi, miso, miso_oe, msel, msel_en} = '0;
		wr(8'h21, 8'hFF);
		wr(8'h1B, 8'h00);
		wr(8'h1D, 8'h0F);
		pls(stop);
		latch_m = 4'h0;
		for (int n = 0; n < 4; n++) trig(n);
		dbit[2] = 1'b1;
		tick(2);
		dbit[2] = 1'b0;
		tick(3);
		latch_m[2] = 1'b0;
		`CHK(cond, {4'h0, latch_m})
		pls(stop);
		latch_m = 4'h0;
		tick(2);
		`CHK(cond, 8'h00)
		wr(8'h1D, 8'h0E);
		trig(0);
		wr(8'h21, 8'hDF);
		trig(1);
		wr(8'h21, 8'hFF);
		wr(8'h1D, 8'h0F);
		// Debounce on pin 0: first close passes, the level then holds
		wr(8'h1B, 8'h40);
		trig(0);
		`CHK(gpin[0], 1'b0)
		// A bounce inside the window gives no second start
		sw_low[0] = 1'b1;
		nst = 0;
		repeat (6) begin
			tick(1);
			nst += (start === 1'b1);
		end
		`CHK(nst, 0)
		`CHK(cond, {4'h0, latch_m})
		sw_low[0] = 1'b0;
		wr(8'h1B, 8'h00);
		tick(3);
		spi = 1'b1;
		for (int n = 0; n < 3; n++) trig(n);
		spi = 1'b0;
		// Interrupt on pins 4 and 5: set, clear by I2C stop, set wins over clear
		wr(8'h1E, 8'hC0);
		pls(iset);
		irq_m = 1'b1;
		chk_drv();
		pls(i2c_stop);
		irq_m = 1'b0;
		chk_drv();
		iset = 1'b1;
		ssn_r = 1'b1;
		tick(1);
		iset = 1'b0;
		ssn_r = 1'b0;
		irq_m = 1'b1;
		chk_drv();
		tally_and_finish();
	end
endmodule // testbench

`default_nettype wire
